// ===== include/exception_entry_defines.vh
// constants for the exception entry logic
`ifndef EXCEPTION_ENTRY_DEFINES_VH
`define EXCEPTION_ENTRY_DEFINES_VH
`define REG_STATUS          5'h0c
`define REG_CAUSE           5'h0d
`define REG_RETURN_ADDR     5'h0e
`define REG_FAULT_ADDR      5'h08
`define VEC_RESET           32'hbfc0_0000
`define VEC_USER_TLB_MISS   32'h8000_0000
`define VEC_GENERAL         32'h8000_0080
`define CLASS_RESET         2'h0
`define CLASS_USER_TLB_MISS 2'h1
`define CLASS_GENERAL       2'h2
`define CODE_INTERRUPT      5'h00
`define CODE_ADDR_LOAD      5'h04
`define CODE_ADDR_STORE     5'h05
`define CODE_TLB_LOAD       5'h02
`define CODE_TLB_STORE      5'h03
`define STATUS_RESET        32'h0000_0000
`define CAUSE_RESET         32'h0000_0000
`define CAUSE_CODE_LSB      2
`define CAUSE_SW_LSB        8
`define CAUSE_IP_LSB        10
`define CAUSE_BD_BIT        31
`define STATUS_MASK_LSB     8
`define READ_DELAY_CYCLES   1
`endif

// ===== core/exception_classifier.v
// sorts an exception code into its class and vector
`timescale 1ns/10ps
`include "exception_entry_defines.vh"
module exception_classifier
(
	input  wire        exc_reset,
	input  wire        exc_user_mode,
	input  wire [4:0]  exc_code,
	output reg  [1:0]  exc_class,
	output reg  [31:0] exc_vector
);
	always @*
	begin
		if (exc_reset)
			exc_class = `CLASS_RESET;
		else if (exc_user_mode &&
			(exc_code == `CODE_TLB_LOAD || exc_code == `CODE_TLB_STORE))
			exc_class = `CLASS_USER_TLB_MISS;
		else
			exc_class = `CLASS_GENERAL;
		case (exc_class)
			`CLASS_RESET:         exc_vector = `VEC_RESET;
			`CLASS_USER_TLB_MISS: exc_vector = `VEC_USER_TLB_MISS;
			default:              exc_vector = `VEC_GENERAL;
		endcase
	end
endmodule // exception_classifier

// ===== core/sysctl_read_port.v
// registered read port for system control coprocessor moves
`timescale 1ns/10ps
`include "exception_entry_defines.vh"
module sysctl_read_port
(
	input  wire        sys_clk,
	input  wire        reset,
	input  wire        rd_en,
	input  wire [4:0]  rd_addr,
	input  wire [31:0] status_value,
	input  wire [31:0] cause_value,
	input  wire [31:0] return_value,
	input  wire [31:0] fault_value,
	output reg  [31:0] rd_data
);
	always @(posedge sys_clk)
	begin
		if (reset)
			rd_data <= 32'h0000_0000;
		else if (rd_en)
		begin
			case (rd_addr)
				`REG_STATUS:      rd_data <= status_value;
				`REG_CAUSE:       rd_data <= cause_value;
				`REG_RETURN_ADDR: rd_data <= return_value;
				`REG_FAULT_ADDR:  rd_data <= fault_value;
				default:          rd_data <= 32'h0000_0000;
			endcase
		end
		else
			rd_data <= 32'h0000_0000;
	end
endmodule // sysctl_read_port

// ===== core/exception_entry_logic.v
// exception entry logic: status stack, cause, return address, vectors
// Function
// - on exception stop task, enter kernel, disable interrupts, fetch from vector
// - exception entry saves the resume address into the return address register
// - exceptions are classed reset, user tlb miss or general; class picks vector
// - cause, return address, status and faulting address registers are readable
// - address error leaves the offending virtual address in the faulting register
// - a coprocessor read completes one clock after the move
// - cause register holds the code telling why the handler was entered
// - interrupts stay disabled after entry until software re-enables them
// - general class goes to 0x8000_0080; unmasked interrupt records interrupt code
// - entry pushes previous to old, current to previous, clears current bits
// - exception return pops old to previous and previous to current
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`include "exception_entry_defines.vh"
module exception_entry_logic
(
	input  wire        sys_clk,
	input  wire        reset,
	input  wire        exc_valid,
	input  wire [4:0]  exc_code,
	input  wire [31:0] exc_pc,
	input  wire        exc_in_delay_slot,
	input  wire [31:0] exc_bad_vaddr,
	input  wire [5:0]  irq_lines,
	input  wire        rfe_valid,
	input  wire        wr_en,
	input  wire [4:0]  wr_addr,
	input  wire [31:0] wr_data,
	input  wire        rd_en,
	input  wire [4:0]  rd_addr,
	output wire [31:0] rd_data,
	output reg         flush,
	output reg         redirect_valid,
	output reg  [31:0] redirect_pc,
	output wire        irq_pending,
	output wire        kernel_mode,
	output wire [31:0] status_out
);
	reg  [31:0] status_reg;
	reg  [31:0] status_next;
	reg  [31:0] cause_reg;
	reg  [31:0] cause_next;
	reg  [31:0] return_addr_reg;
	reg  [31:0] faulting_address_reg;
	reg         reset_seen_reg;
	wire [1:0]  exc_class;
	wire [31:0] exc_vector;
	wire        irq_taken;
	wire        take;
	wire [4:0]  take_code;
	wire [7:0]  pending;

	function is_addr_error;
		input [4:0] code;
		begin
			is_addr_error = (code == `CODE_ADDR_LOAD) || (code == `CODE_ADDR_STORE);
		end
	endfunction

	// status low bits: 0 irq cur, 1 kernel cur, 2/3 previous, 4/5 old
	wire irq_enable_current   = status_reg[0];
	wire kernel_flag_current  = status_reg[1];
	wire irq_enable_previous  = status_reg[2];
	wire kernel_flag_previous = status_reg[3];

	assign pending     = {irq_lines, cause_reg[`CAUSE_SW_LSB+1:`CAUSE_SW_LSB]};
	assign irq_pending = |(pending & status_reg[`STATUS_MASK_LSB+7:`STATUS_MASK_LSB]);
	assign irq_taken   = irq_pending && irq_enable_current && !exc_valid;
	assign take        = exc_valid || irq_taken;
	assign take_code   = exc_valid ? exc_code : `CODE_INTERRUPT;
	// kernel bit set means user here; cleared bit on entry is kernel in the
	// documented sense, so the user flag is the stored bit
	assign kernel_mode = !kernel_flag_current;
	assign status_out  = status_reg;

	exception_classifier classifier
	(
		.exc_reset     (!reset_seen_reg),
		.exc_user_mode (kernel_flag_current),
		.exc_code      (take_code),
		.exc_class     (exc_class),
		.exc_vector    (exc_vector)
	);

	always @*
	begin
		status_next = status_reg;
		if (take)
			status_next[5:0] = {kernel_flag_previous, irq_enable_previous,
				kernel_flag_current, irq_enable_current, 2'b00};
		else if (rfe_valid)
			status_next[3:0] = status_reg[5:2];
		else if (wr_en && wr_addr == `REG_STATUS)
			status_next = wr_data;
	end

	always @*
	begin
		cause_next = cause_reg;
		if (wr_en && wr_addr == `REG_CAUSE)
			cause_next[`CAUSE_SW_LSB+1:`CAUSE_SW_LSB] =
				wr_data[`CAUSE_SW_LSB+1:`CAUSE_SW_LSB];
		cause_next[`CAUSE_IP_LSB+5:`CAUSE_IP_LSB] = irq_lines;
		if (take)
		begin
			cause_next[`CAUSE_CODE_LSB+4:`CAUSE_CODE_LSB] = take_code;
			cause_next[`CAUSE_BD_BIT] = exc_valid && exc_in_delay_slot;
		end
	end

	always @(posedge sys_clk)
	begin
		if (reset)
		begin
			status_reg           <= `STATUS_RESET;
			cause_reg            <= `CAUSE_RESET;
			return_addr_reg      <= 32'h0000_0000;
			faulting_address_reg <= 32'h0000_0000;
			reset_seen_reg       <= 1'b0;
			flush                <= 1'b0;
			redirect_valid       <= 1'b0;
			redirect_pc          <= 32'h0000_0000;
		end
		else
		begin
			reset_seen_reg <= 1'b1;
			status_reg     <= status_next;
			cause_reg      <= cause_next;
			flush          <= take;
			redirect_valid <= take || !reset_seen_reg;
			if (take || !reset_seen_reg)
				redirect_pc <= exc_vector;
			if (take)
				return_addr_reg <= (exc_valid && exc_in_delay_slot) ?
					exc_pc - 32'h0000_0004 : exc_pc;
			if (exc_valid && is_addr_error(exc_code))
				faulting_address_reg <= exc_bad_vaddr;
			else if (wr_en && wr_addr == `REG_FAULT_ADDR)
				faulting_address_reg <= wr_data;
		end
	end

	sysctl_read_port read_port
	(
		.sys_clk      (sys_clk),
		.reset        (reset),
		.rd_en        (rd_en),
		.rd_addr      (rd_addr),
		.status_value (status_reg),
		.cause_value  (cause_reg),
		.return_value (return_addr_reg),
		.fault_value  (faulting_address_reg),
		.rd_data      (rd_data)
	);
endmodule // exception_entry_logic

// ===== bench/exception_entry_logic_asserts.sv
// assertions on the exception entry ports
`timescale 1ns/10ps
`include "exception_entry_defines.vh"
module exception_entry_asserts
(
	input wire        sys_clk, reset, exc_valid, exc_in_delay_slot, rfe_valid, rd_en,
	input wire        flush, redirect_valid, irq_pending, kernel_mode,
	input wire [4:0]  exc_code, rd_addr,
	input wire [31:0] exc_pc, exc_bad_vaddr, rd_data, redirect_pc, status_out
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	a_entry_kernel: assert property (
		exc_valid |=> flush && redirect_valid && kernel_mode && !status_out[0])
		else $error("entry not taken");
	a_general_vector: assert property (
		exc_valid && exc_code == `CODE_ADDR_LOAD |=> redirect_pc == `VEC_GENERAL)
		else $error("general vector wrong");
	a_utlb_vector: assert property (
		exc_valid && exc_code == `CODE_TLB_LOAD && !kernel_mode
		|=> redirect_pc == `VEC_USER_TLB_MISS) else $error("utlb vector wrong");
	a_stack_push: assert property (
		exc_valid |=> status_out[5:0] == {$past(status_out[3:0]), 2'b00})
		else $error("status push wrong");
	a_stack_pop: assert property (
		rfe_valid && !exc_valid && !(irq_pending && status_out[0])
		|=> status_out[3:0] == $past(status_out[5:2])) else $error("status pop wrong");
	a_read_idle: assert property (
		!$past(rd_en) |-> rd_data == 32'h0000_0000) else $error("read data outside slot");
	a_fault_capture: assert property (
		exc_valid && exc_code == `CODE_ADDR_LOAD ##1 rd_en && rd_addr == `REG_FAULT_ADDR
		|=> rd_data == $past(exc_bad_vaddr, 2)) else $error("fault address lost");
	a_return_addr: assert property (
		exc_valid && !exc_in_delay_slot ##1 rd_en && rd_addr == `REG_RETURN_ADDR
		|=> rd_data == $past(exc_pc, 2)) else $error("return address wrong");
endmodule // exception_entry_asserts
bind exception_entry_logic exception_entry_asserts exception_entry_asserts_i (.*);

// ===== bench/tb.sv
// self-checking bench for the exception entry logic
`timescale 1ns/10ps
`include "exception_entry_defines.vh"
module tb;
	reg         sys_clk = 0, reset = 1, exc_valid = 0, rfe_valid = 0, wr_en = 0, rd_en = 0;
	reg         exc_in_delay_slot = 0;
	reg  [4:0]  exc_code = 0, wr_addr = 0, rd_addr = 0;
	reg  [5:0]  irq_lines = 0;
	reg  [31:0] wr_data = 0;
	wire [31:0] rd_data, redirect_pc, status_out;
	wire        flush, redirect_valid, irq_pending, kernel_mode;
	integer     err_total = 0, cmp_count = 0, cyc = 0;
	always #5 sys_clk = ~sys_clk;
	exception_entry_logic exception_entry_logic_i (.sys_clk(sys_clk), .reset(reset),
		.exc_valid(exc_valid), .exc_code(exc_code), .exc_pc(32'h0000_1230),
		.exc_in_delay_slot(exc_in_delay_slot), .exc_bad_vaddr(32'h0000_4567),
		.irq_lines(irq_lines),
		.rfe_valid(rfe_valid), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
		.rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .flush(flush),
		.redirect_valid(redirect_valid), .redirect_pc(redirect_pc),
		.irq_pending(irq_pending), .kernel_mode(kernel_mode), .status_out(status_out));
	task test_done;
	begin
		if (err_total == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
	begin
		cmp_count = cmp_count + 1;
		if (got !== exp)
		begin
			err_total = err_total + 1;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	end
	endtask
	task wr(input [4:0] a, input [31:0] d);
	begin
		@(posedge sys_clk);
		wr_en <= 1;
		wr_addr <= a;
		wr_data <= d;
		@(posedge sys_clk);
		wr_en <= 0;
	end
	endtask
	task rd(input [4:0] a, input [31:0] e);
	begin
		@(posedge sys_clk);
		rd_en <= 1;
		rd_addr <= a;
		@(posedge sys_clk);
		rd_en <= 0;
		#1 chk(rd_data, e);
	end
	endtask
	task exc(input [4:0] c, input [31:0] v);
	begin
		@(posedge sys_clk);
		exc_valid <= 1;
		exc_code <= c;
		@(posedge sys_clk);
		exc_valid <= 0;
		#1 chk(redirect_pc, v);
	end
	endtask
	always @(posedge sys_clk)
	begin
		cyc = cyc + 1;
		if (cyc == 500)
		begin
			err_total = err_total + 1;
			test_done;
		end
	end
	initial
	begin
		repeat (8) @(posedge sys_clk);
		reset <= 0;
		@(posedge sys_clk);
		#1 chk(redirect_pc, `VEC_RESET);
		rd(`REG_STATUS, `STATUS_RESET);
		rd(`REG_CAUSE, `CAUSE_RESET);
		wr(`REG_STATUS, 32'h0000_ff03);
		exc(`CODE_ADDR_LOAD, `VEC_GENERAL);
		rd(`REG_FAULT_ADDR, 32'h0000_4567);
		rd(`REG_CAUSE, 32'h0000_0010);
		rd(`REG_STATUS, 32'h0000_ff0c);
		@(posedge sys_clk);
		rfe_valid <= 1;
		@(posedge sys_clk);
		rfe_valid <= 0;
		#1 chk(status_out & 32'h0000_ff0f, 32'h0000_ff03);
		@(posedge sys_clk);
		irq_lines <= 6'h01;
		@(posedge sys_clk);
		#1 chk(redirect_pc, `VEC_GENERAL);
		chk({31'h0, irq_pending}, 32'h0000_0001);
		chk({31'h0, kernel_mode}, 32'h0000_0001);
		@(posedge sys_clk);
		#1 chk({31'h0, redirect_valid}, 32'h0000_0000);
		rd(`REG_CAUSE, 32'h0000_0400);
		@(posedge sys_clk);
		irq_lines <= 6'h00;
		wr(`REG_STATUS, 32'h0000_0002);
		exc(`CODE_TLB_LOAD, `VEC_USER_TLB_MISS);
		rd(`REG_RETURN_ADDR, 32'h0000_1230);
		exc(`CODE_TLB_LOAD, `VEC_GENERAL);
		@(posedge sys_clk);
		exc_in_delay_slot <= 1;
		exc(`CODE_ADDR_STORE, `VEC_GENERAL);
		exc_in_delay_slot <= 0;
		rd(`REG_RETURN_ADDR, 32'h0000_122c);
		rd(`REG_CAUSE, 32'h8000_0014);
		rd(`REG_FAULT_ADDR, 32'h0000_4567);
		test_done;
	end
endmodule // tb
